// ===== logic/nand_host_pkg.sv
// shared constants, types and command decoding for the flash command host
package nand_host_pkg;

  // clock and pin timing, times in ns, counts derived from the clock period
  localparam int CLK_NS = 100;
  localparam int WE_LOW_NS = 12;
  localparam int DATA_HOLD_NS = 5;
  // read_access_delay: nothing gives a figure, plain default
  localparam int READ_ACCESS_NS = 20;
  localparam int SYNC_STAGES = 2;

  // least times round up, never below one cycle
  function automatic int min_cycles(input int ns);
    int c;
    c = (ns + CLK_NS - 1) / CLK_NS;
    return (c < 1) ? 1 : c;
  endfunction : min_cycles

  localparam logic [3:0] WE_LOW_CYC = 4'(min_cycles(WE_LOW_NS));
  localparam logic [3:0] HOLD_CYC = 4'(min_cycles(DATA_HOLD_NS));
  // strobe stays low long enough for the byte to cross the pin synchroniser
  localparam logic [3:0] READ_LOW_CYC = 4'(min_cycles(READ_ACCESS_NS) + SYNC_STAGES);

  // request kinds on the user port
  typedef enum logic [1:0] {
    KIND_CMD = 2'h0,
    KIND_ADDR = 2'h1,
    KIND_WDATA = 2'h2,
    KIND_RDATA = 2'h3
  } kind_t;

  // pin sequencer states
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_SETUP = 4'h2,
    ST_STROBE = 4'h4,
    ST_HOLD = 4'h8
  } eng_state_t;

  // command codes
  localparam logic [7:0] CMD_READ_SETUP = 8'h00;
  localparam logic [7:0] CMD_READ_CONFIRM = 8'h30;
  localparam logic [7:0] CMD_COPY_READ = 8'h35;
  localparam logic [7:0] CMD_READ_ID = 8'h90;
  localparam logic [7:0] CMD_RESET = 8'hFF;
  localparam logic [7:0] CMD_PROG_SETUP = 8'h80;
  localparam logic [7:0] CMD_COPY_PROG = 8'h85;
  localparam logic [7:0] CMD_PROG_CONFIRM = 8'h10;
  localparam logic [7:0] CMD_PLANE_END = 8'h11;
  localparam logic [7:0] CMD_PLANE2 = 8'h81;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h60;
  localparam logic [7:0] CMD_ERASE_CONFIRM = 8'hD0;
  localparam logic [7:0] CMD_COL_OUT = 8'h05;
  localparam logic [7:0] CMD_COL_OUT_CONFIRM = 8'hE0;
  localparam logic [7:0] CMD_STATUS = 8'h70;
  localparam logic [7:0] CMD_STATUS2 = 8'hF1;
  localparam logic [7:0] SETUP_NONE = CMD_RESET;

  // address cycle counts
  localparam logic [2:0] ADDR_NONE = 3'h0;
  localparam logic [2:0] ADDR_ID = 3'h1;
  localparam logic [2:0] ADDR_COL = 3'h2;
  localparam logic [2:0] ADDR_ROW = 3'h3;
  localparam logic [2:0] ADDR_FULL = 3'h5;

  function automatic logic is_defined(input logic [7:0] c);
    return c inside {CMD_READ_SETUP, CMD_READ_CONFIRM, CMD_COPY_READ, CMD_READ_ID,
      CMD_RESET, CMD_PROG_SETUP, CMD_COPY_PROG, CMD_PROG_CONFIRM, CMD_PLANE_END,
      CMD_PLANE2, CMD_ERASE_SETUP, CMD_ERASE_CONFIRM, CMD_COL_OUT,
      CMD_COL_OUT_CONFIRM, CMD_STATUS, CMD_STATUS2};
  endfunction : is_defined

  function automatic logic is_status_or_reset(input logic [7:0] c);
    return c inside {CMD_STATUS, CMD_STATUS2, CMD_RESET};
  endfunction : is_status_or_reset

  function automatic logic is_write_mode(input logic [7:0] c);
    return c inside {CMD_PROG_SETUP, CMD_COPY_PROG, CMD_PROG_CONFIRM, CMD_PLANE_END,
      CMD_PLANE2, CMD_ERASE_SETUP, CMD_ERASE_CONFIRM};
  endfunction : is_write_mode

  function automatic logic is_program(input logic [7:0] setup);
    return setup inside {CMD_PROG_SETUP, CMD_PLANE2, CMD_COPY_PROG};
  endfunction : is_program

endpackage : nand_host_pkg

// ===== logic/nand_link_if.sv
// request link between the command checker and the pin sequencer
`timescale 1ns/1ns
interface nand_link_if;
  logic valid;
  logic ready;
  nand_host_pkg::kind_t kind;
  logic [7:0] data;
  logic rsp_valid;
  logic [7:0] rsp_data;
  logic dev_ready;

  modport checker_side (output valid, output kind, output data,
    input ready, input rsp_valid, input rsp_data, input dev_ready);
  modport engine (input valid, input kind, input data,
    output ready, output rsp_valid, output rsp_data, output dev_ready);
endinterface : nand_link_if

// ===== logic/nand_strobe_engine.sv
// pin sequencer: one latch or read strobe per request, pins synchronised
`timescale 1ns/1ns
module nand_strobe_engine (
  input wire logic clk_i,
  input wire logic rstn_i,
  nand_link_if.engine link,
  output logic ce_n_o,
  output logic cle_o,
  output logic ale_o,
  output logic we_n_o,
  output logic read_strobe_n_o,
  input wire logic [7:0] io_i,
  output logic [7:0] io_o,
  output logic io_oe_o,
  input wire logic rb_i
);

  typedef struct packed {
    nand_host_pkg::eng_state_t state;
    logic [3:0] cnt;
    nand_host_pkg::kind_t kind;
    logic ce_n;
    logic cle;
    logic ale;
    logic we_n;
    logic read_strobe_n;
    logic [7:0] io_out;
    logic io_oe;
    logic [7:0] io_meta;
    logic [7:0] io_sync;
    logic rb_meta;
    logic rb_sync;
    logic rsp_valid;
    logic [7:0] rsp_data;
  } eng_t;

  localparam eng_t ENG_RESET = '{state: nand_host_pkg::ST_IDLE, cnt: 4'h0,
    kind: nand_host_pkg::KIND_CMD, ce_n: 1'b1, cle: 1'b0, ale: 1'b0, we_n: 1'b1,
    read_strobe_n: 1'b1, io_out: 8'h00, io_oe: 1'b0, io_meta: 8'h00, io_sync: 8'h00,
    rb_meta: 1'b0, rb_sync: 1'b0, rsp_valid: 1'b0, rsp_data: 8'h00};

  eng_t s;
  eng_t next_s;

  // sequence: setup cycle, strobe low, hold cycle, then chip select released
  always_comb begin
    next_s = s;
    next_s.rsp_valid = 1'b0;
    next_s.io_meta = io_i;
    next_s.io_sync = s.io_meta;
    next_s.rb_meta = rb_i;
    next_s.rb_sync = s.rb_meta;
    case (s.state)
      nand_host_pkg::ST_IDLE: begin
        if (link.valid) begin
          next_s.kind = link.kind;
          next_s.ce_n = 1'b0;
          next_s.cle = (link.kind == nand_host_pkg::KIND_CMD);
          next_s.ale = (link.kind == nand_host_pkg::KIND_ADDR);
          next_s.io_out = link.data;
          next_s.io_oe = (link.kind != nand_host_pkg::KIND_RDATA);
          next_s.state = nand_host_pkg::ST_SETUP;
        end
      end
      nand_host_pkg::ST_SETUP: begin
        next_s.state = nand_host_pkg::ST_STROBE;
        if (s.kind == nand_host_pkg::KIND_RDATA) begin
          next_s.read_strobe_n = 1'b0;
          next_s.cnt = nand_host_pkg::READ_LOW_CYC;
        end else begin
          next_s.we_n = 1'b0;
          next_s.cnt = nand_host_pkg::WE_LOW_CYC;
        end
      end
      nand_host_pkg::ST_STROBE: begin
        if (s.cnt == 4'h1) begin
          // rising write strobe latches the byte; data stays for the hold cycle
          next_s.we_n = 1'b1;
          next_s.read_strobe_n = 1'b1;
          next_s.cnt = nand_host_pkg::HOLD_CYC;
          next_s.state = nand_host_pkg::ST_HOLD;
          if (s.kind == nand_host_pkg::KIND_RDATA) begin
            next_s.rsp_valid = 1'b1;
            next_s.rsp_data = s.io_sync;
          end
        end else begin
          next_s.cnt = s.cnt - 4'h1;
        end
      end
      nand_host_pkg::ST_HOLD: begin
        if (s.cnt == 4'h1) begin
          next_s.ce_n = 1'b1;
          next_s.cle = 1'b0;
          next_s.ale = 1'b0;
          next_s.io_oe = 1'b0;
          next_s.state = nand_host_pkg::ST_IDLE;
        end else begin
          next_s.cnt = s.cnt - 4'h1;
        end
      end
      default: next_s = ENG_RESET;
    endcase
  end

  // state register
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s <= ENG_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign link.ready = (s.state == nand_host_pkg::ST_IDLE);
  assign link.rsp_valid = s.rsp_valid;
  assign link.rsp_data = s.rsp_data;
  assign link.dev_ready = s.rb_sync;
  assign ce_n_o = s.ce_n;
  assign cle_o = s.cle;
  assign ale_o = s.ale;
  assign we_n_o = s.we_n;
  assign read_strobe_n_o = s.read_strobe_n;
  assign io_o = s.io_out;
  assign io_oe_o = s.io_oe;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  property p_we_needs_ce;
    !we_n_o |-> !ce_n_o;
  endproperty
  a_we_needs_ce: assert property (p_we_needs_ce) else $error("write strobe without select");

  property p_we_width;
    $fell(we_n_o) |=> we_n_o && !ce_n_o ##1 ce_n_o;
  endproperty
  a_we_width: assert property (p_we_width) else $error("write strobe width or hold wrong");

  property p_float_deselected;
    ce_n_o |-> !io_oe_o;
  endproperty
  a_float_deselected: assert property (p_float_deselected) else $error("bus driven unselected");

  property p_latch_exclusive;
    !(cle_o && ale_o);
  endproperty
  a_latch_exclusive: assert property (p_latch_exclusive) else $error("both latch selects high");

  property p_read_no_drive;
    !read_strobe_n_o |-> !io_oe_o && !ce_n_o;
  endproperty
  a_read_no_drive: assert property (p_read_no_drive) else $error("bus driven during read");

  property p_read_answer;
    $fell(read_strobe_n_o) |-> ##3 link.rsp_valid;
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("read byte not returned");

endmodule : nand_strobe_engine

// ===== logic/nand_command_host.sv
// flash command host: checks command sequences and drives the flash pins
`timescale 1ns/1ns
// Behaviour
// - every byte written by pulsing write strobe low while chip select is low.
// - reset and both status reads are single-cycle commands; read ID opens one address cycle.
// - page read is 00h, five addresses, 30h; copy-back read confirms 35h.
// - page program is 80h, five addresses, data, 10h; copy-back uses 85h.
// - block erase is 60h, three row addresses, then D0h.
// - two-plane program: 80h ... 11h, then 81h ... 10h.
// - between 11h and 81h only status reads or reset may be issued.
// - in-page random input is 85h plus column; random output 05h, column, E0h.
// - host never issues a command code outside the defined set.
// - write-mode commands, addresses and data need write protect high.
module nand_command_host (
  input wire logic CLK_I,
  input wire logic RSTN_I,
  input wire logic REQ_VALID_I,
  input wire logic [1:0] REQ_KIND_I,
  input wire logic [7:0] REQ_BYTE_I,
  output logic REQ_READY_O,
  output logic RSP_VALID_O,
  output logic [7:0] RSP_BYTE_O,
  output logic ERR_O,
  input wire logic PROTECT_I,
  output logic BUSY_O,
  output logic CE_N_O,
  output logic CLE_O,
  output logic ALE_O,
  output logic WE_N_O,
  output logic READ_STROBE_N_O,
  output logic WP_N_O,
  input wire logic [7:0] SHARED_IO_BUS_I,
  output logic [7:0] SHARED_IO_BUS_O,
  output logic SHARED_IO_BUS_OE_O,
  input wire logic RB_I
);

  typedef struct packed {
    logic [7:0] setup;
    logic [2:0] addr_need;
    logic [2:0] addr_cnt;
    logic plane_gap;
    logic wp_n;
    logic err;
    logic rsp_valid;
    logic [7:0] rsp_data;
  } host_t;

  localparam host_t HOST_RESET = '{setup: nand_host_pkg::SETUP_NONE,
    addr_need: nand_host_pkg::ADDR_NONE, addr_cnt: 3'h0, plane_gap: 1'b0,
    wp_n: 1'b0, err: 1'b0, rsp_valid: 1'b0, rsp_data: 8'h00};

  nand_link_if link ();

  host_t s;
  host_t next_s;
  nand_host_pkg::kind_t kind;
  logic busy;
  logic addr_done;
  logic prog_open;
  logic confirm_ok;
  logic refuse;
  logic take;

  // address cycles a command opens; 85h means random input once a program is open
  function automatic logic [2:0] addr_need_of(input logic [7:0] c, input logic prog);
    case (c)
      nand_host_pkg::CMD_READ_SETUP: return nand_host_pkg::ADDR_FULL;
      nand_host_pkg::CMD_PROG_SETUP: return nand_host_pkg::ADDR_FULL;
      nand_host_pkg::CMD_PLANE2: return nand_host_pkg::ADDR_FULL;
      nand_host_pkg::CMD_COPY_PROG: begin
        return prog ? nand_host_pkg::ADDR_COL : nand_host_pkg::ADDR_FULL;
      end
      nand_host_pkg::CMD_ERASE_SETUP: return nand_host_pkg::ADDR_ROW;
      nand_host_pkg::CMD_COL_OUT: return nand_host_pkg::ADDR_COL;
      nand_host_pkg::CMD_READ_ID: return nand_host_pkg::ADDR_ID;
      default: return nand_host_pkg::ADDR_NONE;
    endcase
  endfunction : addr_need_of

  assign kind = nand_host_pkg::kind_t'(REQ_KIND_I);
  assign busy = !link.dev_ready;
  assign addr_done = (s.addr_need != nand_host_pkg::ADDR_NONE) && (s.addr_cnt == s.addr_need);
  assign prog_open = nand_host_pkg::is_program(s.setup) && addr_done;

  // a confirm only follows its own setup with all its address cycles sent
  always_comb begin
    case (REQ_BYTE_I)
      nand_host_pkg::CMD_READ_CONFIRM,
      nand_host_pkg::CMD_COPY_READ: begin
        confirm_ok = (s.setup == nand_host_pkg::CMD_READ_SETUP) && addr_done;
      end
      nand_host_pkg::CMD_PROG_CONFIRM: confirm_ok = prog_open;
      nand_host_pkg::CMD_PLANE_END: begin
        confirm_ok = (s.setup == nand_host_pkg::CMD_PROG_SETUP) && addr_done;
      end
      nand_host_pkg::CMD_ERASE_CONFIRM: begin
        confirm_ok = (s.setup == nand_host_pkg::CMD_ERASE_SETUP) && addr_done;
      end
      nand_host_pkg::CMD_COL_OUT_CONFIRM: begin
        confirm_ok = (s.setup == nand_host_pkg::CMD_COL_OUT) && addr_done;
      end
      default: confirm_ok = 1'b1;
    endcase
  end

  // refusal check; a refused request is consumed and flagged, never sent to the pins
  always_comb begin
    case (kind)
      nand_host_pkg::KIND_CMD: begin
        refuse = !nand_host_pkg::is_defined(REQ_BYTE_I)
          || (busy && !nand_host_pkg::is_status_or_reset(REQ_BYTE_I))
          || (s.plane_gap && !nand_host_pkg::is_status_or_reset(REQ_BYTE_I)
              && REQ_BYTE_I != nand_host_pkg::CMD_PLANE2)
          || (!s.plane_gap && REQ_BYTE_I == nand_host_pkg::CMD_PLANE2)
          || (nand_host_pkg::is_write_mode(REQ_BYTE_I) && PROTECT_I)
          || !confirm_ok;
      end
      nand_host_pkg::KIND_ADDR: begin
        refuse = (s.addr_cnt == s.addr_need) || busy
          || (nand_host_pkg::is_write_mode(s.setup) && PROTECT_I);
      end
      nand_host_pkg::KIND_WDATA: refuse = !prog_open || PROTECT_I || busy;
      nand_host_pkg::KIND_RDATA: refuse = 1'b0;
      default: refuse = 1'b1;
    endcase
  end

  assign REQ_READY_O = link.ready;
  assign take = REQ_VALID_I && link.ready;
  assign link.valid = take && !refuse;
  assign link.kind = kind;
  assign link.data = REQ_BYTE_I;

  // sequence tracking; status reads leave an open sequence untouched
  always_comb begin
    next_s = s;
    next_s.err = take && refuse;
    next_s.wp_n = !PROTECT_I;
    next_s.rsp_valid = link.rsp_valid;
    if (link.rsp_valid) begin
      next_s.rsp_data = link.rsp_data;
    end
    if (link.valid) begin
      case (kind)
        nand_host_pkg::KIND_CMD: begin
          if (REQ_BYTE_I != nand_host_pkg::CMD_STATUS
              && REQ_BYTE_I != nand_host_pkg::CMD_STATUS2) begin
            next_s.addr_need = addr_need_of(REQ_BYTE_I, prog_open);
            next_s.addr_cnt = 3'h0;
            next_s.setup = (next_s.addr_need != nand_host_pkg::ADDR_NONE)
              ? REQ_BYTE_I : nand_host_pkg::SETUP_NONE;
            next_s.plane_gap = (REQ_BYTE_I == nand_host_pkg::CMD_PLANE_END);
          end
        end
        nand_host_pkg::KIND_ADDR: next_s.addr_cnt = s.addr_cnt + 3'h1;
        default: next_s = next_s;
      endcase
    end
  end

  // state register
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      s <= HOST_RESET;
    end else begin
      s <= next_s;
    end
  end

  nand_strobe_engine u_engine (
    .clk_i(CLK_I),
    .rstn_i(RSTN_I),
    .link(link.engine),
    .ce_n_o(CE_N_O),
    .cle_o(CLE_O),
    .ale_o(ALE_O),
    .we_n_o(WE_N_O),
    .read_strobe_n_o(READ_STROBE_N_O),
    .io_i(SHARED_IO_BUS_I),
    .io_o(SHARED_IO_BUS_O),
    .io_oe_o(SHARED_IO_BUS_OE_O),
    .rb_i(RB_I)
  );

  assign RSP_VALID_O = s.rsp_valid;
  assign RSP_BYTE_O = s.rsp_data;
  assign ERR_O = s.err;
  assign WP_N_O = s.wp_n;
  assign BUSY_O = busy;

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RSTN_I);

  property p_defined_only;
    link.valid && kind == nand_host_pkg::KIND_CMD |-> nand_host_pkg::is_defined(link.data);
  endproperty
  a_defined_only: assert property (p_defined_only) else $error("undefined command sent");

  property p_undefined_flagged;
    take && kind == nand_host_pkg::KIND_CMD && !nand_host_pkg::is_defined(REQ_BYTE_I)
      |=> ERR_O ##1 !ERR_O || $past(take);
  endproperty
  a_undefined_flagged: assert property (p_undefined_flagged) else $error("no error flag");

  property p_busy_filter;
    link.valid && kind == nand_host_pkg::KIND_CMD && busy
      |-> nand_host_pkg::is_status_or_reset(link.data);
  endproperty
  a_busy_filter: assert property (p_busy_filter) else $error("command sent while busy");

  property p_plane_gap;
    link.valid && kind == nand_host_pkg::KIND_CMD && s.plane_gap
      |-> nand_host_pkg::is_status_or_reset(link.data) || link.data == nand_host_pkg::CMD_PLANE2;
  endproperty
  a_plane_gap: assert property (p_plane_gap) else $error("illegal command in plane gap");

  property p_protect_pin;
    PROTECT_I ##1 PROTECT_I |-> !WP_N_O;
  endproperty
  a_protect_pin: assert property (p_protect_pin) else $error("write protect not driven");

  property p_protect_block;
    link.valid && (kind == nand_host_pkg::KIND_WDATA
      || (kind == nand_host_pkg::KIND_CMD && nand_host_pkg::is_write_mode(link.data)))
      |-> !PROTECT_I;
  endproperty
  a_protect_block: assert property (p_protect_block) else $error("write under protect");

  property p_addr_limit;
    link.valid && kind == nand_host_pkg::KIND_ADDR |-> s.addr_cnt < s.addr_need
      ##1 s.addr_cnt == $past(s.addr_cnt) + 3'h1;
  endproperty
  a_addr_limit: assert property (p_addr_limit) else $error("address cycle count wrong");

  property p_erase_rows;
    link.valid && kind == nand_host_pkg::KIND_CMD
      && link.data == nand_host_pkg::CMD_ERASE_SETUP |=> s.addr_need == nand_host_pkg::ADDR_ROW;
  endproperty
  a_erase_rows: assert property (p_erase_rows) else $error("erase address count wrong");

endmodule : nand_command_host

// ===== tb/nand_dev_model.sv
// behavioural flash device standing on the far side of the command host
`timescale 1ns/1ns
module nand_dev_model #(
  parameter int BUSY_NS = 4000
) (
  input wire logic ce_n_i,
  input wire logic cle_i,
  input wire logic ale_i,
  input wire logic we_n_i,
  input wire logic read_strobe_n_i,
  input wire logic wp_n_i,
  input wire logic [7:0] io_i,
  output logic [7:0] io_o,
  output logic io_oe_o,
  output logic rb_o
);
  logic [7:0] cmd = 8'hFF;
  logic [7:0] col = 8'h00;
  logic [7:0] dlast = 8'h00;
  logic busy = 1'b0;
  logic stat = 1'b0;
  int acnt = 0;
  int dcnt = 0;
  int ops = 0;
  initial io_o = 8'h00;
  initial io_oe_o = 1'b0;
  // open drain pulled low only while an array operation runs, chip select or not
  assign rb_o = !busy;
  // bytes latch on the write strobe rise; latch selects tell their kind apart
  always @(posedge we_n_i) begin
    if (!ce_n_i && cle_i && (!busy || io_i inside {8'hFF, 8'h70, 8'hF1})) begin
      cmd = io_i;
      acnt = 0;
      stat = io_i inside {8'h70, 8'hF1};
      // protect low keeps the pump off, so program and erase never start
      if (io_i inside {8'h30, 8'h35} || (wp_n_i && io_i inside {8'h10, 8'hD0})) begin
        ops++;
        busy = 1'b1;
        busy <= #(BUSY_NS) 1'b0;
      end
    end else if (!ce_n_i && ale_i && !busy) begin
      acnt++;
      if (acnt == 1) col = io_i;
    end else if (!ce_n_i && !cle_i && !busy) begin
      dcnt++;
      dlast = io_i;
    end
  end
  // each read strobe fall with chip select low puts out the next data byte and steps the column while ready, or the status byte in status mode
  always @(negedge read_strobe_n_i) begin
    if (!ce_n_i && (stat || !busy)) begin
      io_o = stat ? {1'b0, !busy, 6'h00} : 8'hA0 + col;
      if (!stat) col++;
      io_oe_o = 1'b1;
    end
  end
  // a released bus shows the inverse, so a stale byte can never pass
  always @(posedge read_strobe_n_i or posedge ce_n_i) begin
    // invert once per release; a second release edge must not restore the byte
    if (io_oe_o) io_o = ~io_o;
    io_oe_o = 1'b0;
  end
endmodule : nand_dev_model

// ===== tb/tb_top.sv
// self-checking bench for the flash command host
`timescale 1ns/1ns
module tb_top;
  localparam logic [1:0] k_cmd = nand_host_pkg::KIND_CMD;
  localparam logic [1:0] k_addr = nand_host_pkg::KIND_ADDR;
  localparam logic [1:0] k_data = nand_host_pkg::KIND_WDATA;
  localparam logic [1:0] k_read = nand_host_pkg::KIND_RDATA;
  logic CLK_I = 1'b0;
  logic RSTN_I = 1'b0;
  logic REQ_VALID_I = 1'b0;
  logic [1:0] REQ_KIND_I = 2'h0;
  logic [7:0] REQ_BYTE_I = 8'h00;
  logic PROTECT_I = 1'b0;
  logic REQ_READY_O, RSP_VALID_O, ERR_O, BUSY_O, CE_N_O, CLE_O, ALE_O, WE_N_O;
  logic READ_STROBE_N_O, WP_N_O, SHARED_IO_BUS_OE_O, RB_I, dev_oe;
  logic [7:0] RSP_BYTE_O, SHARED_IO_BUS_O, dev_io, bus;
  int failures = 0;
  int comparisons = 0;
  // the host sets the shared bus level while its drivers are enabled, otherwise the device output does
  assign bus = SHARED_IO_BUS_OE_O ? SHARED_IO_BUS_O : dev_io;
  always #50 CLK_I = ~CLK_I;
  // host and device driving at once would fight on the shared bus
  always @(negedge CLK_I) begin
    if (SHARED_IO_BUS_OE_O === 1'b1 && dev_oe === 1'b1) check1(1'b0, 1'b1);
  end
  nand_command_host i_nand_command_host (.CLK_I(CLK_I), .RSTN_I(RSTN_I),
    .REQ_VALID_I(REQ_VALID_I), .REQ_KIND_I(REQ_KIND_I), .REQ_BYTE_I(REQ_BYTE_I),
    .REQ_READY_O(REQ_READY_O), .RSP_VALID_O(RSP_VALID_O), .RSP_BYTE_O(RSP_BYTE_O),
    .ERR_O(ERR_O), .PROTECT_I(PROTECT_I), .BUSY_O(BUSY_O), .CE_N_O(CE_N_O), .CLE_O(CLE_O),
    .ALE_O(ALE_O), .WE_N_O(WE_N_O), .READ_STROBE_N_O(READ_STROBE_N_O), .WP_N_O(WP_N_O),
    .SHARED_IO_BUS_I(bus), .SHARED_IO_BUS_O(SHARED_IO_BUS_O),
    .SHARED_IO_BUS_OE_O(SHARED_IO_BUS_OE_O), .RB_I(RB_I));
  nand_dev_model #(.BUSY_NS(4000)) i_nand_dev_model (.ce_n_i(CE_N_O), .cle_i(CLE_O),
    .ale_i(ALE_O), .we_n_i(WE_N_O), .read_strobe_n_i(READ_STROBE_N_O), .wp_n_i(WP_N_O),
    .io_i(bus),
    .io_o(dev_io), .io_oe_o(dev_oe), .rb_o(RB_I));

  task automatic wrap_up;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : wrap_up

  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : check8

  task automatic check1(input logic got, input logic exp);
    check8({7'h00, got}, {7'h00, exp});
  endtask : check1

  // bounded wait for the request port; running out ends the run
  task automatic wait_ready;
    int n;
    n = 0;
    while (REQ_READY_O !== 1'b1 && n < 200) begin
      @(negedge CLK_I);
      n++;
    end
    if (REQ_READY_O !== 1'b1) begin
      check1(1'b0, 1'b1);
      wrap_up();
    end
  endtask : wait_ready

  task automatic wait_busy(input logic lvl);
    int n;
    n = 0;
    while (BUSY_O !== lvl && n < 100) begin
      @(negedge CLK_I);
      n++;
    end
    check1(BUSY_O, lvl);
    if (BUSY_O !== lvl) begin
      wrap_up();
    end
  endtask : wait_busy

  // one request, refusal judged, returns once the pin sequence has ended
  task automatic send(input logic [1:0] k, input logic [7:0] b, input logic err);
    @(posedge CLK_I);
    REQ_VALID_I <= 1'b1;
    REQ_KIND_I <= k;
    REQ_BYTE_I <= b;
    @(negedge CLK_I);
    wait_ready();
    @(posedge CLK_I);
    REQ_VALID_I <= 1'b0;
    // the refusal flag stands only in the cycle after the take
    @(negedge CLK_I);
    check1(ERR_O, err);
    wait_ready();
  endtask : send

  task automatic rd(input logic [7:0] exp);
    send(k_read, 8'h00, 1'b0);
    check1(RSP_VALID_O, 1'b1);
    check8(RSP_BYTE_O, exp);
  endtask : rd

  task automatic t_reset;
    repeat (4) @(posedge CLK_I);
    check1(CE_N_O, 1'b1);
    check1(SHARED_IO_BUS_OE_O, 1'b0);
    RSTN_I <= 1'b1;
    repeat (4) @(posedge CLK_I);
    wait_busy(1'b0);
    $display("test reset done");
  endtask : t_reset

  task automatic t_single;
    logic [7:0] codes [4] = '{8'h90, 8'hFF, 8'hF1, 8'h70};
    foreach (codes[i]) begin
      send(k_cmd, codes[i], 1'b0);
      check8(i_nand_dev_model.cmd, codes[i]);
    end
    rd(8'h40);
    $display("test single cycle commands done");
  endtask : t_single

  task automatic t_page;
    logic [7:0] pa [5] = '{8'h03, 8'h00, 8'h01, 8'h00, 8'h00};
    send(k_cmd, 8'h00, 1'b0);
    foreach (pa[i]) send(k_addr, pa[i], 1'b0);
    check8(8'(i_nand_dev_model.acnt), 8'h05);
    send(k_cmd, 8'h30, 1'b0);
    wait_busy(1'b1);
    send(k_cmd, 8'h80, 1'b1);
    send(k_cmd, 8'h70, 1'b0);
    rd(8'h00);
    wait_busy(1'b0);
    send(k_cmd, 8'h00, 1'b0);
    rd(8'hA3);
    rd(8'hA4);
    send(k_cmd, 8'h05, 1'b0);
    send(k_addr, 8'h10, 1'b0);
    send(k_addr, 8'h00, 1'b0);
    send(k_cmd, 8'hE0, 1'b0);
    rd(8'hB0);
    $display("test page read done");
  endtask : t_page

  task automatic t_erase;
    @(posedge CLK_I);
    PROTECT_I <= 1'b1;
    repeat (2) @(negedge CLK_I);
    check1(WP_N_O, 1'b0);
    send(k_cmd, 8'h60, 1'b1);
    send(k_cmd, 8'h80, 1'b1);
    @(posedge CLK_I);
    PROTECT_I <= 1'b0;
    send(k_cmd, 8'h42, 1'b1);
    send(k_cmd, 8'h10, 1'b1);
    send(k_cmd, 8'h60, 1'b0);
    repeat (3) send(k_addr, 8'h40, 1'b0);
    send(k_addr, 8'h00, 1'b1);
    send(k_cmd, 8'hD0, 1'b0);
    wait_busy(1'b1);
    check8(8'(i_nand_dev_model.ops), 8'h02);
    wait_busy(1'b0);
    $display("test protect and erase done");
  endtask : t_erase

  task automatic t_plane;
    send(k_cmd, 8'h81, 1'b1);
    send(k_cmd, 8'h80, 1'b0);
    repeat (5) send(k_addr, 8'h00, 1'b0);
    send(k_data, 8'h5A, 1'b0);
    send(k_cmd, 8'h11, 1'b0);
    send(k_cmd, 8'h60, 1'b1);
    send(k_cmd, 8'h70, 1'b0);
    send(k_cmd, 8'h81, 1'b0);
    repeat (5) send(k_addr, 8'h00, 1'b0);
    send(k_data, 8'hA5, 1'b0);
    check8(8'(i_nand_dev_model.dcnt), 8'h02);
    check8(i_nand_dev_model.dlast, 8'hA5);
    send(k_cmd, 8'h85, 1'b0);
    repeat (2) send(k_addr, 8'h08, 1'b0);
    send(k_addr, 8'h00, 1'b1);
    send(k_data, 8'hC3, 1'b0);
    check8(i_nand_dev_model.dlast, 8'hC3);
    send(k_cmd, 8'h10, 1'b0);
    wait_busy(1'b1);
    check8(8'(i_nand_dev_model.ops), 8'h03);
    wait_busy(1'b0);
    $display("test two plane program done");
  endtask : t_plane

  initial begin
    t_reset();
    t_single();
    t_page();
    t_erase();
    t_plane();
    wrap_up();
  end
endmodule : tb_top
